/* File: host_model.sv */
// Host microcontroller model driving the three-wire and I2C display links.
// Assumes the bench clock; sda_wire is the resolved data line.
module host_model
  import lcd_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           sda_wire,
  output lcd_pkg::host_link_t drv,
  output int                  ack_count
);
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_pkg::*;
  // --------------------------------------------------------------------------
  // Link tasks
  // --------------------------------------------------------------------------
  initial
  begin
    drv = '{data: 1'b1, clock: 1'b0, load: 1'b0};
    ack_count = 0;
  end

  task w(input int n);
    repeat (n) @(posedge clock);
  endtask : w

  task tw_frame(input logic [SEG_COUNT-1:0] v);
    for (int i = SEG_COUNT - 1; i >= 0; i--)
    begin
      drv.data <= v[i];
      drv.clock <= 1'b0;
      w(1);
      drv.clock <= 1'b1;
      w(1);
    end
    drv.clock <= 1'b0;
    w(2);
    drv.load <= 1'b1;
    w(3);
    drv.load <= 1'b0;
  endtask : tw_frame

  task i2c_bit(input logic b);
    w(2);
    drv.data <= b;
    w(8);
    drv.clock <= 1'b1;
    w(8);
    drv.clock <= 1'b0;
  endtask : i2c_bit

  task i2c_frame(input logic [SEG_COUNT-1:0] v);
    logic [SEG_COUNT+15:0] s;
    s = {16'h5AC3, v};
    drv.load <= 1'b0;
    drv.data <= 1'b1;
    drv.clock <= 1'b1;
    w(8);
    drv.data <= 1'b0;
    w(8);
    drv.clock <= 1'b0;
    for (int i = SEG_COUNT + 15; i >= 0; i--)
    begin
      if (i == 7)
      begin
        // Short clock spike that the line filter must swallow
        w(3);
        drv.clock <= 1'b1;
        w(2);
        drv.clock <= 1'b0;
      end
      i2c_bit(s[i]);
      if (i % 8 == 0)
      begin
        w(2);
        drv.data <= 1'b1;
        w(8);
        drv.clock <= 1'b1;
        w(4);
        if (sda_wire === 1'b0) ack_count++;
        w(4);
        drv.clock <= 1'b0;
      end
    end
    w(2);
    drv.data <= 1'b0;
    w(8);
    drv.clock <= 1'b1;
    w(8);
    drv.data <= 1'b1;
    w(8);
  endtask : i2c_frame
endmodule : host_model

/* File: lcd_pkg.sv */
// Shared constants, enumerations and carrier types of the segment LCD driver control.
// Assumes a single 50 MHz system clock; every other timing is counted on it.
package lcd_pkg;

  // ----------------------------------------------------------------------------
  // Geometry and division
  // ----------------------------------------------------------------------------
  localparam int SEG_COUNT     = 160;
  localparam int COM_COUNT     = 4;
  localparam int OSC_DIV       = 16;       // Divided clock ratio
  localparam int FRAME_DIV     = 24;       // Oscillator ticks per frame
  localparam int I2C_BITS      = 8;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int CLK_HZ         = 50_000_000;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int GLITCH_NS      = 50;
  localparam int FILT_CYC       = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int RESET_HOLD_NS  = 200;
  localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_INT_HZ     = 28_800;
  localparam int OSC_HALF_CYC   = CLK_HZ / (2 * OSC_INT_HZ);

  // ----------------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------------
  localparam logic DISPLAY_ON_RST = 1'b0;
  localparam logic SYNC_N_RST     = 1'b1;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DUTY_STATIC  = 2'b00,
    DUTY_HALF    = 2'b01,
    DUTY_THIRD   = 2'b10,
    DUTY_QUARTER = 2'b11
  } duty_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_BITS = 2'b01,
    LINK_ACK  = 2'b11
  } link_state_t;

  typedef struct packed {
    logic master_role;
    logic duty_sel_bit1;
    logic duty_sel_bit0;
    logic bias_half;
    logic osc_internal;
    logic i2c_sel;
    logic power_clear_disable;
  } straps_t;

  typedef struct packed {
    logic data;
    logic clock;
    logic load;
  } host_link_t;

endpackage : lcd_pkg

/* File: segment_lcd_driver_control.sv */
// Control logic of a 160-output segment LCD driver: straps, host shift link,
// display latch, oscillator division and common scan with cascade sync.
// Assumes all pins are synchronous to clock; analog drive levels are outside.
module segment_lcd_driver_control
  import lcd_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire lcd_pkg::straps_t          straps,
  input  wire lcd_pkg::host_link_t       link,
  input  wire logic                      init_n,
  input  wire logic                      display_on_cmd,
  input  wire logic                      display_off_cmd,
  input  wire logic                      osc_input,
  input  wire logic                      common_sync_n_in,
  output logic [lcd_pkg::SEG_COUNT-1:0]  segment_outputs,
  output logic [lcd_pkg::COM_COUNT-1:0]  common_outputs,
  output logic                           frame_polarity,
  output logic                           bias_half,
  output logic                           divided_clock_out,
  output logic                           common_sync_n_out,
  output logic                           common_sync_n_oe,
  output logic                           osc_output,
  output logic                           osc_output_oe,
  output logic                           ack_drain_out,
  output logic                           ack_drain_oe,
  output logic                           reset_pullup_on,
  output logic                           display_on
);

  // Counter widths below are sized for these constants
  if (SEG_COUNT < 8 || COM_COUNT != 4 || FILT_CYC < 1 || FILT_CYC > 8 || OSC_DIV != 16 ||
      FRAME_DIV > 31 || OSC_HALF_CYC < 2 || OSC_HALF_CYC > 1024)
  begin : g_bad_constants
    $error("segment_lcd_driver_control: unsupported constants");
  end

  duty_t duty;
  assign duty = duty_t'({straps.duty_sel_bit1, straps.duty_sel_bit0});

  // ----------------------------------------------------------------------------
  // Input glitch filter for data and shift clock, active in I2C mode only
  // ----------------------------------------------------------------------------
  logic [1:0] raw_line;
  wire  [1:0] filt_q;
  assign raw_line = {link.clock, link.data};

  for (genvar g = 0; g < 2; g++)
  begin : g_filter
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic       filt_d;
    logic       filt_bit_q;

    assign filt_q[g] = filt_bit_q;

    always_comb
    begin
      cnt_d  = 3'h0;
      filt_d = filt_bit_q;
      if (!straps.i2c_sel)
        filt_d = raw_line[g];
      else if (raw_line[g] != filt_bit_q)
      begin
        if (cnt_q == 3'(FILT_CYC - 1))
          filt_d = raw_line[g];
        else
          cnt_d = cnt_q + 3'h1;
      end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
      if (!rst_n)
      begin
        cnt_q     <= 3'h0;
        filt_bit_q <= 1'b1;
      end
      else
      begin
        cnt_q     <= cnt_d;
        filt_bit_q <= filt_d;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Host link: shift register, latch, acknowledge
  // ----------------------------------------------------------------------------
  // One spare stage keeps the oldest data bit that a stop condition's clock high shifts along
  logic [SEG_COUNT:0]   shift_q, shift_d;
  logic [SEG_COUNT-1:0] latch_q, latch_d;
  logic [3:0]           bit_cnt_q, bit_cnt_d;
  link_state_t          lstate_q, lstate_d;
  logic                 ack_q, ack_d;
  logic                 scl_prev_q, sda_prev_q;
  logic                 scl_rise, scl_fall, i2c_start, i2c_stop;

  always_comb
  begin
    scl_rise  = filt_q[1] & ~scl_prev_q;
    scl_fall  = ~filt_q[1] & scl_prev_q;
    i2c_start = filt_q[1] & scl_prev_q & sda_prev_q & ~filt_q[0];
    i2c_stop  = filt_q[1] & scl_prev_q & ~sda_prev_q & filt_q[0];
    shift_d   = shift_q;
    latch_d   = latch_q;
    bit_cnt_d = bit_cnt_q;
    lstate_d  = lstate_q;
    ack_d     = ack_q;
    if (!straps.i2c_sel)
    begin
      lstate_d = LINK_IDLE;
      ack_d    = 1'b0;
      if (scl_rise)
        shift_d = {shift_q[SEG_COUNT-1:0], filt_q[0]};
      if (link.load)
        latch_d = shift_q[SEG_COUNT-1:0];
    end
    else
    begin
      unique case (lstate_q)
        LINK_IDLE:
        begin
          ack_d = 1'b0;
        end
        LINK_BITS:
        begin
          if (scl_rise && bit_cnt_q != 4'(I2C_BITS))
          begin
            shift_d   = {shift_q[SEG_COUNT-1:0], filt_q[0]};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          else if (scl_fall && bit_cnt_q == 4'(I2C_BITS))
          begin
            ack_d     = 1'b1;
            bit_cnt_d = 4'h0;
            lstate_d  = LINK_ACK;
          end
        end
        LINK_ACK:
        begin
          if (scl_fall)
          begin
            ack_d    = 1'b0;
            lstate_d = LINK_BITS;
          end
        end
        default:
        begin
          lstate_d = LINK_IDLE;
        end
      endcase
      if (i2c_stop && lstate_q != LINK_IDLE)
      begin
        // Drop the stray bit of the clock high that carries the stop
        if (bit_cnt_q == 4'h1)
          latch_d = shift_q[SEG_COUNT:1];
        else
          latch_d = shift_q[SEG_COUNT-1:0];
        ack_d    = 1'b0;
        lstate_d = LINK_IDLE;
      end
      if (i2c_start)
      begin
        bit_cnt_d = 4'h0;
        ack_d     = 1'b0;
        lstate_d  = LINK_BITS;
      end
    end
    if (!init_n)
    begin
      shift_d   = '0;
      latch_d   = '0;
      bit_cnt_d = 4'h0;
      lstate_d  = LINK_IDLE;
      ack_d     = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q    <= '0;
      latch_q    <= '0;
      bit_cnt_q  <= 4'h0;
      lstate_q   <= LINK_IDLE;
      ack_q      <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      shift_q    <= shift_d;
      latch_q    <= latch_d;
      bit_cnt_q  <= bit_cnt_d;
      lstate_q   <= lstate_d;
      ack_q      <= ack_d;
      scl_prev_q <= filt_q[1];
      sda_prev_q <= filt_q[0];
    end
  end

  // ----------------------------------------------------------------------------
  // Oscillator, divided clock and common scan
  // ----------------------------------------------------------------------------
  logic [9:0] int_cnt_q, int_cnt_d;
  logic       int_osc_q, int_osc_d;
  logic       osc_prev_q, sync_prev_q;
  logic [2:0] div_cnt_q, div_cnt_d;
  logic       div_clk_q, div_clk_d;
  logic [4:0] tick_q, tick_d;
  logic [1:0] phase_q, phase_d;
  logic       pol_q, pol_d;
  logic       osc_tick, sync_fall;
  logic [4:0] phase_len;
  logic [1:0] last_phase;

  always_comb
  begin
    int_cnt_d = int_cnt_q + 10'h1;
    int_osc_d = int_osc_q;
    if (int_cnt_q == 10'(OSC_HALF_CYC - 1))
    begin
      int_cnt_d = 10'h0;
      int_osc_d = ~int_osc_q;
    end
    if (straps.osc_internal)
      osc_tick = int_cnt_q == 10'(OSC_HALF_CYC - 1) && !int_osc_q;
    else
      osc_tick = osc_input & ~osc_prev_q;
    sync_fall = sync_prev_q & ~common_sync_n_in;
    unique case (duty)
      DUTY_STATIC:  begin phase_len = 5'(FRAME_DIV);     last_phase = 2'd0; end
      DUTY_HALF:    begin phase_len = 5'(FRAME_DIV / 2); last_phase = 2'd1; end
      DUTY_THIRD:   begin phase_len = 5'(FRAME_DIV / 3); last_phase = 2'd2; end
      DUTY_QUARTER: begin phase_len = 5'(FRAME_DIV / 4); last_phase = 2'd3; end
    endcase
    div_cnt_d = div_cnt_q;
    div_clk_d = div_clk_q;
    tick_d    = tick_q;
    phase_d   = phase_q;
    pol_d     = pol_q;
    if (osc_tick)
    begin
      div_cnt_d = div_cnt_q + 3'h1;
      if (div_cnt_q == 3'(OSC_DIV / 2 - 1))
        div_clk_d = ~div_clk_q;
      if (tick_q >= phase_len - 5'h1)
      begin
        tick_d = 5'h0;
        if (phase_q >= last_phase)
        begin
          phase_d = 2'd0;
          pol_d   = ~pol_q;
        end
        else
          phase_d = phase_q + 2'd1;
      end
      else
        tick_d = tick_q + 5'h1;
    end
    if (!straps.master_role)
    begin
      div_cnt_d = 3'h0;
      div_clk_d = 1'b0;
      if (sync_fall)
      begin
        tick_d  = 5'h0;
        phase_d = 2'd0;
      end
    end
    if (!init_n)
    begin
      div_cnt_d = 3'h0;
      div_clk_d = 1'b0;
      tick_d    = 5'h0;
      phase_d   = 2'd0;
      pol_d     = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_cnt_q   <= 10'h0;
      int_osc_q   <= 1'b0;
      osc_prev_q  <= 1'b0;
      sync_prev_q <= 1'b1;
      div_cnt_q   <= 3'h0;
      div_clk_q   <= 1'b0;
      tick_q      <= 5'h0;
      phase_q     <= 2'd0;
      pol_q       <= 1'b0;
    end
    else
    begin
      int_cnt_q   <= int_cnt_d;
      int_osc_q   <= int_osc_d;
      osc_prev_q  <= osc_input;
      sync_prev_q <= common_sync_n_in;
      div_cnt_q   <= div_cnt_d;
      div_clk_q   <= div_clk_d;
      tick_q      <= tick_d;
      phase_q     <= phase_d;
      pol_q       <= pol_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Display state and registered pins
  // ----------------------------------------------------------------------------
  logic                 disp_d;
  logic [COM_COUNT-1:0] com_sel;

  always_comb
  begin
    disp_d = display_on;
    if (display_on_cmd)
      disp_d = 1'b1;
    if (display_off_cmd)
      disp_d = 1'b0;
    if (!init_n)
      disp_d = DISPLAY_ON_RST;
    unique case (duty)
      DUTY_STATIC:  com_sel = 4'hF;
      DUTY_HALF:    com_sel = phase_q[0] ? 4'hA : 4'h5;
      DUTY_THIRD:   com_sel = (phase_q == 2'd0) ? 4'h1 : (phase_q == 2'd1) ? 4'hA : 4'h4;
      DUTY_QUARTER: com_sel = 4'(4'h1 << phase_q);
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      display_on        <= DISPLAY_ON_RST;
      segment_outputs   <= '0;
      common_outputs    <= '0;
      frame_polarity    <= 1'b0;
      bias_half         <= 1'b0;
      divided_clock_out <= 1'b0;
      common_sync_n_out <= SYNC_N_RST;
      common_sync_n_oe  <= 1'b0;
      osc_output        <= 1'b0;
      osc_output_oe     <= 1'b0;
      ack_drain_out     <= 1'b0;
      ack_drain_oe      <= 1'b0;
      reset_pullup_on   <= 1'b0;
    end
    else
    begin
      display_on        <= disp_d;
      segment_outputs   <= display_on ? latch_q : '0;
      common_outputs    <= display_on ? com_sel : '0;
      frame_polarity    <= pol_q & display_on;
      bias_half         <= straps.bias_half;
      divided_clock_out <= div_clk_q;
      common_sync_n_out <= !(phase_q == 2'd0 && tick_q == 5'h0);
      common_sync_n_oe  <= straps.master_role;
      osc_output        <= straps.osc_internal & int_osc_q;
      osc_output_oe     <= straps.osc_internal;
      ack_drain_out     <= 1'b0;
      ack_drain_oe      <= ack_q & straps.i2c_sel;
      reset_pullup_on   <= ~straps.power_clear_disable;
    end
  end

endmodule : segment_lcd_driver_control

/* File: segment_lcd_driver_control_checker.sv */
// Concurrent checks on the pins of the LCD driver control.
// Assumes straps only change while rst_n is low.
module segment_lcd_driver_control_checker
  import lcd_pkg::*;
(
  input wire logic                          clock,
  input wire logic                          rst_n,
  input wire lcd_pkg::straps_t              straps,
  input wire logic                          init_n,
  input wire logic                          display_on_cmd,
  input wire logic                          display_off_cmd,
  input wire logic [lcd_pkg::SEG_COUNT-1:0] segment_outputs,
  input wire logic [lcd_pkg::COM_COUNT-1:0] common_outputs,
  input wire logic                          bias_half,
  input wire logic                          divided_clock_out,
  input wire logic                          common_sync_n_out,
  input wire logic                          common_sync_n_oe,
  input wire logic                          osc_output_oe,
  input wire logic                          ack_drain_out,
  input wire logic                          ack_drain_oe,
  input wire logic                          reset_pullup_on,
  input wire logic                          display_on
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_off_dark: assert property (!display_on |=> segment_outputs == '0 && common_outputs == '0)
    else $error("pins active while display off");
  a_on_cmd: assert property (display_on_cmd && !display_off_cmd && init_n |=> display_on)
    else $error("display on command ignored");
  a_off_cmd: assert property (display_off_cmd |=> !display_on)
    else $error("display off command ignored");
  a_init_clear: assert property (!init_n |=> !display_on ##1 segment_outputs == '0)
    else $error("init did not clear display");
  a_static_com: assert property (straps[5:4] == 2'b00 |-> common_outputs inside {4'h0, 4'hF})
    else $error("static commons differ");
  a_pair_com: assert property (straps[5] != straps[4] |-> common_outputs[1] == common_outputs[3]
    && (straps[5] || common_outputs[0] == common_outputs[2]))
    else $error("paired commons differ");
  a_ack_drain: assert property (!ack_drain_out && (straps.i2c_sel || !ack_drain_oe))
    else $error("acknowledge drain misused");
  a_slave_clk: assert property (!straps.master_role |-> !divided_clock_out)
    else $error("slave divided clock not low");
  a_strap_copy: assert property (rst_n |=> {bias_half, common_sync_n_oe, osc_output_oe,
    reset_pullup_on} == {$past(straps.bias_half), $past(straps.master_role),
    $past(straps.osc_internal), !$past(straps.power_clear_disable)})
    else $error("strap outputs wrong");

  c_display_on: cover property ($rose(display_on));
  c_ack: cover property ($rose(ack_drain_oe));
  c_sync: cover property ($fell(common_sync_n_out));
endmodule : segment_lcd_driver_control_checker

/* File: segment_lcd_driver_control_tb_top.sv */
// Self-checking bench for the LCD driver control.
// Assumes lcd_pkg, host_model and the checker are compiled first.
module segment_lcd_driver_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lcd_pkg::*;
  // --------------------------------------------------------------------------
  // Stimulus and checks
  // --------------------------------------------------------------------------
  localparam int OSC_P = 8;
  logic                 clock, rst_n, init_n, on_cmd, off_cmd, sync_drv;
  logic                 divc, sync_out, sync_oe, ack_oe;
  logic                 fpol, osc_o, osc_oe_o, bias_o, pull_o, disp_o, ack_o, p;
  logic [2:0]           osc_cnt;
  logic [31:0]          seed;
  logic [SEG_COUNT-1:0] seg, prev, v;
  logic [COM_COUNT-1:0] com;
  logic [SEG_COUNT-1:0] q[$];
  logic [3:0]           pat[4] = '{4'hF, 4'h5, 4'h1, 4'h1};
  straps_t              straps;
  host_link_t           drv, link;
  int                   ack_count, mismatches, check_count, cycles;
  time                  t0;
  wire                  sync_wire = sync_oe ? sync_out : sync_drv;
  assign link = '{data: drv.data & ~ack_oe, clock: drv.clock, load: drv.load};

  segment_lcd_driver_control segment_lcd_driver_control_inst (
    .clock(clock), .rst_n(rst_n), .straps(straps), .link(link), .init_n(init_n),
    .display_on_cmd(on_cmd), .display_off_cmd(off_cmd), .osc_input(osc_cnt[2]),
    .common_sync_n_in(sync_wire), .segment_outputs(seg), .common_outputs(com),
    .frame_polarity(fpol), .bias_half(bias_o), .divided_clock_out(divc),
    .common_sync_n_out(sync_out), .common_sync_n_oe(sync_oe), .osc_output(osc_o),
    .osc_output_oe(osc_oe_o), .ack_drain_out(ack_o), .ack_drain_oe(ack_oe),
    .reset_pullup_on(pull_o), .display_on(disp_o));
  host_model host_model_inst (.clock(clock), .sda_wire(link.data), .drv(drv),
    .ack_count(ack_count));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  task newv;
    repeat (5)
    begin
      seed = xs(seed);
      v = {v[SEG_COUNT-33:0], seed};
    end
  endtask : newv

  task chk(input logic [SEG_COUNT-1:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task cmd(input logic on);
    if (on) on_cmd <= 1'b1;
    else off_cmd <= 1'b1;
    @(posedge clock);
    on_cmd <= 1'b0;
    off_cmd <= 1'b0;
    host_model_inst.w(4);
  endtask : cmd

  task cfg(input logic [6:0] s);
    rst_n <= 1'b0;
    straps <= s;
    host_model_inst.w(3);
    rst_n <= 1'b1;
    host_model_inst.w(2);
  endtask : cfg

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock)
  begin
    // Also stands for the master's divided clock feeding a slave
    osc_cnt <= osc_cnt + 3'h1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // Each change of the segment pins while rst_n is high consumes the oldest expected value
  always @(negedge clock)
  begin
    prev <= seg;
    if (rst_n && seg !== prev) chk(seg, q.size() ? q.pop_front() : prev);
  end

  initial
  begin
    {rst_n, on_cmd, off_cmd, osc_cnt, cycles, check_count, mismatches} = '0;
    {init_n, sync_drv, prev, v} = '1;
    straps = 7'b1111100;
    seed = 32'h93576858;
    host_model_inst.w(12);
    rst_n <= 1'b1;
    host_model_inst.w(2);
    newv();
    host_model_inst.tw_frame(v);
    chk(seg, '0);
    q.push_back(v);
    cmd(1'b1);
    newv();
    q.push_back(v);
    host_model_inst.tw_frame(v);
    q.push_back('0);
    cmd(1'b0);
    q.push_back(v);
    cmd(1'b1);
    q.push_back('0);
    init_n <= 1'b0;
    host_model_inst.w(10);
    init_n <= 1'b1;
    host_model_inst.w(4);
    chk({bias_o, osc_oe_o, pull_o, disp_o, ack_o}, 5'b11100);
    @(posedge osc_o);
    t0 = $time;
    @(negedge osc_o);
    chk($time - t0, OSC_HALF_CYC * CLK_PERIOD_NS);
    $display("test three_wire done");
    cfg(7'b1111011);
    cmd(1'b1);
    chk({bias_o, osc_oe_o, pull_o, disp_o, ack_o}, 5'b10010);
    newv();
    q.push_back(v);
    host_model_inst.i2c_frame(v);
    chk(ack_count, 22);
    $display("test i2c done");
    for (int d = 0; d < 4; d++)
    begin
      cfg({1'b1, d[1:0], d[0], 3'b000});
      cmd(1'b1);
      @(negedge sync_out);
      t0 = $time;
      host_model_inst.w(6);
      chk(com, pat[d]);
      p = fpol;
      @(negedge sync_out);
      chk($time - t0, FRAME_DIV * OSC_P * CLK_PERIOD_NS);
      host_model_inst.w(1);
      chk(fpol, !p);
      @(posedge divc);
      t0 = $time;
      @(posedge divc);
      chk($time - t0, OSC_DIV * OSC_P * CLK_PERIOD_NS);
    end
    $display("test master done");
    cfg(7'b0110000);
    cmd(1'b1);
    repeat (3)
    begin
      seed = xs(seed);
      host_model_inst.w(20 + seed[6:0]);
      sync_drv <= 1'b0;
      host_model_inst.w(6);
      chk(com, 4'h1);
      host_model_inst.w(2);
      sync_drv <= 1'b1;
    end
    $display("test slave done");
    chk(q.size(), 0);
    stop_test();
  end
endmodule : segment_lcd_driver_control_tb_top

bind segment_lcd_driver_control segment_lcd_driver_control_checker chk_inst (.*);
